// file: ext_bus_pkg.sv
package ext_bus_pkg;

    // external bus widths and wishbone address width
    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;
    localparam int WB_AW  = 8;

    // register byte offsets on the wishbone bus
    localparam logic [WB_AW-1:0] REG_CTRL   = 8'h00;
    localparam logic [WB_AW-1:0] REG_TIMING = 8'h04;
    localparam logic [WB_AW-1:0] REG_ADDR   = 8'h08;
    localparam logic [WB_AW-1:0] REG_WDATA  = 8'h0C;
    localparam logic [WB_AW-1:0] REG_STATUS = 8'h10;
    localparam logic [WB_AW-1:0] REG_RDATA  = 8'h14;

    // control register bit positions
    localparam int CTRL_START_BIT   = 0;
    localparam int CTRL_WRITE_BIT   = 1;
    localparam int CTRL_RDY_EN_BIT  = 2;
    localparam int CTRL_RDY_POL_BIT = 3;
    localparam int CTRL_ASYNC_BIT   = 4;
    localparam int CTRL_MUX_BIT     = 5;

    // timing register field positions (phase lengths in bus clocks)
    localparam int TIM_AB_LSB = 0;
    localparam int TIM_C_LSB  = 4;
    localparam int TIM_D_LSB  = 8;
    localparam int TIM_E_LSB  = 12;
    localparam int TIM_F_LSB  = 20;

    // status register bit positions
    localparam int STAT_BUSY_BIT  = 0;
    localparam int STAT_DONE_BIT  = 1;
    localparam int STAT_WAITS_LSB = 8;

    // legal range of the address setup phase
    localparam logic [2:0] AB_MIN = 3'h1;
    localparam logic [2:0] AB_MAX = 3'h5;

    // reset values
    localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
    localparam logic [31:0] TIMING_RESET = 32'h0000_0001;

    // clock figures: system clock and generated bus reference clock
    localparam int CLK_PERIOD_NS    = 50;
    localparam int BUSCLK_PERIOD_NS = 400;
    localparam int TCS_CLKS         = BUSCLK_PERIOD_NS / CLK_PERIOD_NS;

    // programmed phase lengths; e holds length minus one
    typedef struct packed {
        logic [1:0] f;
        logic [4:0] e;
        logic       d;
        logic [1:0] c;
        logic [2:0] ab;
    } timing_t;

    // cycle options
    typedef struct packed {
        logic mux;
        logic async_rdy;
        logic rdy_pol;
        logic rdy_en;
        logic write;
    } ctrl_t;

    // bus cycle phases, one-hot
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_AB   = 7'h02,
        ST_C    = 7'h04,
        ST_D    = 7'h08,
        ST_E    = 7'h10,
        ST_RDY  = 7'h20,
        ST_F    = 7'h40
    } phase_t;

endpackage

// file: pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,   // system clock
    input  wire logic         rst_b, // async reset, active low
    input  wire logic [W-1:0] pin,   // asynchronous pin level
    output logic      [W-1:0] sync   // synchronised level
);
    logic [W-1:0] meta_q;

    // two stages; only the second stage reads the first
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_q <= '0;
            sync   <= '0;
        end else begin
            meta_q <= pin;
            sync   <= meta_q;
        end
    end
endmodule

// file: bus_clk_gen.sv
`timescale 1ns/1ps
module bus_clk_gen #(
    parameter int DIV = 8
) (
    input  wire logic clk,     // system clock
    input  wire logic rst_b,   // async reset, active low
    output logic      bus_clk, // bus reference clock out
    output logic      tick     // pulse at the end of each bus clock
);
    localparam int CW = $clog2(DIV);
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);
    localparam logic [CW-1:0] HALF = CW'(DIV / 2);

    logic [CW-1:0] cnt_q;

    generate
        if (DIV < 2 || (DIV % 2) != 0) begin : g_bad_div
            $error("bus_clk_gen: DIV must be even and at least 2");
        end
    endgenerate

    // high in the first half of each period, tick on its last clock
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q   <= '0;
            bus_clk <= 1'b0;
            tick    <= 1'b0;
        end else begin
            cnt_q   <= (cnt_q == LAST) ? '0 : cnt_q + 1'b1;
            bus_clk <= (cnt_q == LAST) || (cnt_q < HALF - 1'b1);
            tick    <= (cnt_q == LAST - 1'b1);
        end
    end
endmodule

// file: ext_bus_ready_wait_control.sv
// The register offsets and register access over Wishbone are this design's own decisions.
`timescale 1ns/1ps
// Overview of operation
// (R1) read data is captured on the edge that raises the read strobe
// (R2) address changes late in a read never touch captured data
// (R3) partner may drop read data after read strobe rises
// (R4) ready input from partner extends or ends the bus cycle
// (R5) ready active level is chosen by a control bit
// (R6) synchronous ready sampled directly; partner keeps it in step with bus clock
// (R7) asynchronous ready adds a stage and at least one wait state
// (R8) partner holds async ready one bus clock plus setup time
// (R9) partner may drop ready after the strobe's rising edge
// (R10) partner drops stale ready before next cycle's first sample point
// (R11) first ready sample point follows the programmed phase lengths
// (R12) ready inactive at sample point inserts one wait state, resample
// (R13) ready active at sample point finishes the bus cycle
// (R14) async sample point sits one synchroniser delay later
// (R15) programmed access wait states complete before ready is evaluated
// (R16) cycle runs address setup, command, data setup, access, hold
// (R17) ready only lengthens the access phase
// (R18) without ready control access ends after its programmed length
module ext_bus_ready_wait_control
    import ext_bus_pkg::*;
#(
    parameter int TCS_DIV = TCS_CLKS
) (
    input  wire logic                     clk,         // system clock
    input  wire logic                     rst_b,       // async reset
    input  wire logic                     wb_cyc_i,    // wishbone cycle
    input  wire logic                     wb_stb_i,    // wishbone strobe
    input  wire logic                     wb_we_i,     // wishbone write
    input  wire logic [ext_bus_pkg::WB_AW-1:0] wb_adr_i, // byte address
    input  wire logic [3:0]               wb_sel_i,    // byte enables
    input  wire logic [31:0]              wb_dat_i,    // write data
    output logic      [31:0]              wb_dat_o,    // read data
    output logic                          wb_ack_o,    // acknowledge
    output logic                          bus_reference_clock, // bus clock
    output logic [ext_bus_pkg::ADDR_W-1:0] ext_addr,   // address pins
    output logic                          ale,         // address latch
    output logic                          rd_b,        // read strobe
    output logic                          wr_b,        // write strobe
    input  wire logic [ext_bus_pkg::DATA_W-1:0] data_in, // data pins in
    output logic [ext_bus_pkg::DATA_W-1:0] data_out,   // data pins out
    output logic                          data_oe_b,   // low = drive
    input  wire logic                     ready_in     // ready pin
);
    import ext_bus_pkg::*;

    generate
        if (TCS_DIV < 2 || (TCS_DIV % 2) != 0) begin : g_bad_div
            $error("TCS_DIV must be even and at least 2");
        end
    endgenerate

    // register file
    ctrl_t               ctrl_q;       // options for the next cycle
    timing_t             timing_q;     // phase lengths for the next cycle
    logic [ADDR_W-1:0]   addr_q;
    logic [DATA_W-1:0]   wdata_q;
    logic [DATA_W-1:0]   rdata_q;
    logic                done_q;
    logic [7:0]          waits_q;
    logic                start_q;      // start accepted, waiting for tick

    // copies frozen for the running cycle
    ctrl_t               cyc_ctrl_q;
    timing_t             cyc_tim_q;

    // cycle sequencer
    phase_t              state_q;
    phase_t              state_d;
    logic [4:0]          cnt_q;
    logic [4:0]          cnt_d;
    phase_t              leave_st;
    logic [4:0]          leave_cnt;
    logic                finish;       // access phase ends this edge
    logic                rdy_wait;     // stay in or enter a wait state

    // pins after synchronisation
    logic                rdy_s;
    logic [DATA_W-1:0]   din_s;
    logic                rdy_act;
    logic                rdy_a_q;

    logic                tick;
    logic                wb_hit;
    logic                wb_wr;
    logic [31:0]         rd_mux;
    logic                busy;
    logic [31:0]         wmerge;       // register word after byte lanes
    ctrl_t               cur_ctrl;     // options as the pins see them

    bus_clk_gen #(
        .DIV     (TCS_DIV)
    ) u_clk (
        .clk     (clk),
        .rst_b   (rst_b),
        .bus_clk (bus_reference_clock),
        .tick    (tick)
    );

    pin_sync #(
        .W     (1)
    ) u_rdy_sync (
        .clk   (clk),
        .rst_b (rst_b),
        .pin   (ready_in),
        .sync  (rdy_s)
    );

    pin_sync #(
        .W     (DATA_W)
    ) u_data_sync (
        .clk   (clk),
        .rst_b (rst_b),
        .pin   (data_in),
        .sync  (din_s)
    );

    // byte-lane merge for wishbone writes
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  sel);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // keep the address setup phase within its legal length
    function automatic logic [2:0] clamp_ab(input logic [2:0] v);
        if (v < AB_MIN) begin
            return AB_MIN;
        end else if (v > AB_MAX) begin
            return AB_MAX;
        end
        return v;
    endfunction

    assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wb_wr  = wb_hit && wb_we_i;
    assign busy   = start_q || (state_q != ST_IDLE);

    // the read mux holds the current word, so one merge serves all
    assign wmerge = merge(rd_mux, wb_dat_i, wb_sel_i);

    // options freeze on the edge entering address setup; until then
    // the pins must follow the live copy or they lag one clock
    assign cur_ctrl = (state_q == ST_IDLE) ? ctrl_q : cyc_ctrl_q;

    // ready level after polarity selection
    assign rdy_act = (rdy_s == cyc_ctrl_q.rdy_pol);          // see (R5)

    // wishbone acknowledge: one cycle after the request, then drop
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_hit;
        end
    end

    // register read mux; unmapped offsets read as zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (wb_adr_i)
            REG_CTRL:   rd_mux = {26'h0, ctrl_q, 1'b0};
            REG_TIMING: rd_mux = {10'h0, timing_q.f, 3'h0,
                                  timing_q.e, 3'h0, timing_q.d, 2'h0,
                                  timing_q.c, 1'h0, timing_q.ab};
            REG_ADDR:   rd_mux = {8'h0, addr_q};
            REG_WDATA:  rd_mux = {16'h0, wdata_q};
            REG_STATUS: rd_mux = {16'h0, waits_q, 6'h0, done_q, busy};
            REG_RDATA:  rd_mux = {16'h0, rdata_q};
            default:    rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (wb_hit && !wb_we_i) begin
            wb_dat_o <= rd_mux;
        end
    end

    // configuration registers; cycle options are frozen at start
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_q   <= ctrl_t'(CTRL_RESET[5:1]);
            timing_q <= timing_t'(TIMING_RESET[12:0]);
            addr_q   <= '0;
            wdata_q  <= '0;
        end else if (wb_wr) begin
            unique case (wb_adr_i)
                REG_CTRL: begin
                    ctrl_q <= ctrl_t'(wmerge[CTRL_MUX_BIT:CTRL_WRITE_BIT]);
                end
                REG_TIMING: begin
                    timing_q.ab <= clamp_ab(wmerge[TIM_AB_LSB +: 3]);
                    timing_q.c  <= wmerge[TIM_C_LSB +: 2];
                    timing_q.d  <= wmerge[TIM_D_LSB];
                    timing_q.e  <= wmerge[TIM_E_LSB +: 5];
                    timing_q.f  <= wmerge[TIM_F_LSB +: 2];
                end
                REG_ADDR: begin
                    addr_q <= wmerge[ADDR_W-1:0];
                end
                REG_WDATA: begin
                    wdata_q <= wmerge[DATA_W-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // start request: ignored while a cycle is pending or running
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            start_q <= 1'b0;
        end else if (start_q && tick) begin
            start_q <= 1'b0;
        end else if (wb_wr && wb_adr_i == REG_CTRL && wb_sel_i[0]
                     && wb_dat_i[CTRL_START_BIT] && !busy) begin
            start_q <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cyc_ctrl_q <= ctrl_t'(CTRL_RESET[5:1]);
            cyc_tim_q  <= timing_t'(TIMING_RESET[12:0]);
        end else if (start_q && tick) begin
            cyc_ctrl_q <= ctrl_q;
            cyc_tim_q  <= timing_q;
        end
    end

    // where a phase goes when it has run out; zero-length phases skip
    always_comb begin
        leave_st  = ST_IDLE;
        leave_cnt = 5'h00;
        unique case (state_q)
            ST_AB: begin                                      // see (R16)
                if (cyc_tim_q.c != 2'h0) begin
                    leave_st  = ST_C;
                    leave_cnt = {3'h0, 2'(cyc_tim_q.c - 2'h1)};
                end else if (cyc_tim_q.d) begin
                    leave_st  = ST_D;
                end else begin
                    leave_st  = ST_E;
                    leave_cnt = cyc_tim_q.e;
                end
            end
            ST_C: begin
                if (cyc_tim_q.d) begin
                    leave_st  = ST_D;
                end else begin
                    leave_st  = ST_E;
                    leave_cnt = cyc_tim_q.e;
                end
            end
            ST_D: begin
                leave_st  = ST_E;
                leave_cnt = cyc_tim_q.e;
            end
            ST_E, ST_RDY: begin
                if (cyc_tim_q.f != 2'h0) begin                // see (R17)
                    leave_st  = ST_F;
                    leave_cnt = {3'h0, 2'(cyc_tim_q.f - 2'h1)};
                end
            end
            ST_IDLE, ST_F: begin
                leave_st = ST_IDLE;
            end
            default: begin
                leave_st = ST_IDLE;
            end
        endcase
    end

    // ready evaluation at the end of the programmed access length
    always_comb begin
        finish   = 1'b0;
        rdy_wait = 1'b0;
        if (tick && state_q == ST_E && cnt_q == 5'h00) begin  // see (R15)
            if (!cyc_ctrl_q.rdy_en) begin
                finish = 1'b1;                                // see (R18)
            end else if (cyc_ctrl_q.async_rdy) begin
                rdy_wait = 1'b1;                              // see (R7)
            end else if (rdy_act) begin
                finish = 1'b1;                                // see (R6) (R13)
            end else begin
                rdy_wait = 1'b1;                              // see (R12)
            end
        end else if (tick && state_q == ST_RDY) begin
            // async samples the extra stage, one bus clock later
            if (cyc_ctrl_q.async_rdy ? rdy_a_q : rdy_act) begin  // see (R14)
                finish = 1'b1;                                // see (R4) (R13)
            end else begin
                rdy_wait = 1'b1;                              // see (R12)
            end
        end
    end

    // next phase and bus-clock count
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        if (tick) begin
            if (state_q == ST_IDLE) begin
                if (start_q) begin
                    state_d = ST_AB;
                    cnt_d   = {2'h0, 3'(clamp_ab(timing_q.ab) - 3'h1)};
                end
            end else if (rdy_wait) begin
                state_d = ST_RDY;                             // see (R11)
                cnt_d   = 5'h00;
            end else if (finish) begin
                state_d = leave_st;
                cnt_d   = leave_cnt;
            end else if (state_q == ST_E || cnt_q != 5'h00) begin
                cnt_d = cnt_q - 5'h01;
            end else begin
                state_d = leave_st;
                cnt_d   = leave_cnt;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= ST_IDLE;
            cnt_q   <= 5'h00;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
        end
    end

    // extra synchroniser stage for asynchronous ready, one per bus clock
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdy_a_q <= 1'b0;
        end else if (tick) begin
            rdy_a_q <= rdy_act;                               // see (R7) (R14)
        end
    end

    // read data taken on the very edge that raises the read strobe;
    // it comes from the data pipeline, so the address plays no part
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_q <= '0;
        end else if (finish && !cyc_ctrl_q.write) begin
            rdata_q <= din_s;                                 // see (R1) (R2) (R3)
        end
    end

    // wait-state counter for the last cycle, and sticky done flag
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            waits_q <= 8'h00;
        end else if (tick && start_q && state_q == ST_IDLE) begin
            waits_q <= 8'h00;
        end else if (rdy_wait && waits_q != 8'hFF) begin
            waits_q <= waits_q + 8'h01;
        end
    end

    // set wins over a software clear in the same cycle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            done_q <= 1'b0;
        end else if (state_q != ST_IDLE && state_d == ST_IDLE) begin
            done_q <= 1'b1;
        end else if (wb_wr && wb_adr_i == REG_STATUS && wb_sel_i[0]
                     && wb_dat_i[STAT_DONE_BIT]) begin
            done_q <= 1'b0;
        end
    end

    // pin drivers follow the next phase so they switch with it
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ext_addr  <= '0;
            ale       <= 1'b0;
            rd_b      <= 1'b1;
            wr_b      <= 1'b1;
            data_out  <= '0;
            data_oe_b <= 1'b1;
        end else begin
            if (state_d == ST_AB) begin
                ext_addr <= addr_q;
            end
            ale  <= (state_d == ST_AB);
            // strobes only span access and ready wait states
            rd_b <= !(!cyc_ctrl_q.write
                      && (state_d == ST_E || state_d == ST_RDY)); // see (R17)
            wr_b <= !(cyc_ctrl_q.write
                      && (state_d == ST_E || state_d == ST_RDY));
            if (cur_ctrl.mux && state_d == ST_AB) begin
                data_out  <= addr_q[DATA_W-1:0];
                data_oe_b <= 1'b0;
            end else if (cyc_ctrl_q.write
                         && (state_d == ST_D || state_d == ST_E
                             || state_d == ST_RDY || state_d == ST_F
                             || (!cyc_ctrl_q.mux && state_d == ST_C))) begin
                data_out  <= wdata_q;
                data_oe_b <= 1'b0;
            end else begin
                data_oe_b <= 1'b1;
            end
        end
    end
endmodule

// file: ext_bus_ready_wait_control_props.sv
`timescale 1ns/1ps
module ext_bus_props (
    input wire logic clk,      // system clock
    input wire logic rst_b,    // reset, active low
    input wire logic wb_cyc_i, // bus cycle
    input wire logic wb_stb_i, // bus strobe
    input wire logic wb_ack_o, // acknowledge
    input wire logic ale,      // address phase
    input wire logic rd_b,     // read strobe
    input wire logic wr_b,     // write strobe
    input wire logic data_oe_b // low = drive
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // register bus answers once per request
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    // phases never overlap
    a_strb_apart: assert property (rd_b || wr_b)
        else $error("both strobes low");
    a_ale_quiet: assert property (ale |-> rd_b && wr_b)
        else $error("strobe in address phase");
    // phases last whole bus clocks of 8 clk
    a_rd_min: assert property ($fell(rd_b) |-> !rd_b [*8])
        else $error("read access too short");
    a_ale_min: assert property ($rose(ale) |-> ale [*8])
        else $error("address phase too short");
    // pins turned round so the far side can answer
    a_rd_float: assert property (!rd_b |-> data_oe_b)
        else $error("driving during read");
    a_wr_drive: assert property (!wr_b |-> !data_oe_b)
        else $error("write data not driven");
    c_read: cover property ($rose(rd_b));
    c_write: cover property ($rose(wr_b));
    c_mux: cover property (ale && !data_oe_b);
endmodule
bind ext_bus_ready_wait_control ext_bus_props i_ext_bus_props (
    .clk(clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .ale(ale),
    .rd_b(rd_b), .wr_b(wr_b), .data_oe_b(data_oe_b));

// file: ext_mem_model.sv
`timescale 1ns/1ps
module ext_mem_model
    import ext_bus_pkg::*;
(
    input  wire logic clk,   // system clock
    input  wire logic bck,   // bus reference clock
    input  wire logic rd_b,  // read strobe
    input  wire logic wr_b,  // write strobe
    input  wire logic [ext_bus_pkg::ADDR_W-1:0] addr, // address
    input  wire logic [ext_bus_pkg::DATA_W-1:0] wdat, // write data
    input  wire logic [3:0] waits, // bus clocks before ready
    input  wire logic pol,   // ready active level
    output logic [ext_bus_pkg::DATA_W-1:0] rdat, // read data
    output logic rdy         // ready pin
);
    logic [DATA_W-1:0] mem [16];
    logic [DATA_W-1:0] last_q = '0;
    logic [3:0]        cnt_q = '0;
    logic              rdy_q = 1'b0;
    // ready moves on the falling bus clock so it is settled when
    // sampled; it is held until the strobe rises again
    always @(negedge bck) begin
        if (rd_b && wr_b) begin
            cnt_q <= 4'h0;
            rdy_q <= !pol;
        end else begin
            if (cnt_q >= waits) rdy_q <= pol;
            cnt_q <= cnt_q + 4'h1;
        end
    end
    // write data lands while the write strobe is low
    always @(posedge clk) begin
        if (!wr_b) mem[addr[3:0]] <= wdat;
        if (!rd_b) last_q <= rdat;
    end
    // after the read strobe rises the pins show garbage
    assign rdat = rd_b ? ~last_q : mem[addr[3:0]];
    assign rdy = rdy_q;
endmodule

// file: test_ext_bus_ready_wait_control.sv
`timescale 1ns/1ps
module test_ext_bus_ready_wait_control;
    import ext_bus_pkg::*;
    logic clk = 1'b0, rst_b = 1'b0, cyc = 1'b0, stb = 1'b0;
    logic we = 1'b0, ack, bck, ale, rd_b, wr_b, oe_b, rdy;
    logic md_pol = 1'b1;
    logic [3:0] md_waits = 4'h0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wd = 32'h0, rd, tim_x = 32'h0;
    logic [23:0] addr;
    logic [15:0] din, dout;
    int run = 0, low_clks = 0, fail_count = 0, tests_run = 0;
    always #25 clk = ~clk;
    ext_bus_ready_wait_control i_ext_bus_ready_wait_control (
        .clk(clk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wd),
        .wb_dat_o(rd), .wb_ack_o(ack), .bus_reference_clock(bck),
        .ext_addr(addr), .ale(ale), .rd_b(rd_b), .wr_b(wr_b),
        .data_in(din), .data_out(dout), .data_oe_b(oe_b),
        .ready_in(rdy));
    ext_mem_model i_ext_mem_model (
        .clk(clk), .bck(bck), .rd_b(rd_b), .wr_b(wr_b), .addr(addr),
        .wdat(dout), .waits(md_waits), .pol(md_pol), .rdat(din),
        .rdy(rdy));
    // length of the last strobe in clk cycles
    always @(posedge clk) begin
        if (!(rd_b && wr_b)) run <= run + 1;
        else if (run != 0) begin
            low_clks <= run;
            run <= 0;
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one classic cycle; holds the request until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wd <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (n == 20) fail_count++;
        r = rd;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    // program access length, clear done, start, poll for done
    task automatic cycle(input logic [31:0] ctl, input logic [4:0] e,
                         output logic [31:0] st);
        int n;
        n = 0;
        wb(1'b1, REG_TIMING, 32'h1 | tim_x | (32'(e) << TIM_E_LSB), st);
        wb(1'b1, REG_STATUS, 32'h2, st);
        wb(1'b1, REG_CTRL, ctl | 32'h1, st);
        do begin
            wb(1'b0, REG_STATUS, 32'h0, st);
            n++;
        end while (st[STAT_DONE_BIT] !== 1'b1 && n < 100);
        if (n == 100) fail_count++;
    endtask
    // read cycle against a partner that answers after w bus clocks
    task automatic rdy_case(input logic [31:0] ctl, input logic [3:0] w,
                            input logic [4:0] e, input int ws);
        logic [31:0] st;
        md_waits <= w;
        md_pol <= ctl[CTRL_RDY_POL_BIT];
        cycle(ctl, e, st);
        chk(32'(st[15:8]), 32'(ws));
        chk(32'(low_clks), 32'((e + 1 + ws) * 8));
    endtask
    task automatic t_reset;
        logic [31:0] r;
        wb(1'b0, REG_CTRL, 32'h0, r);
        chk(r, CTRL_RESET);
        wb(1'b0, REG_TIMING, 32'h0, r);
        chk(r, TIMING_RESET);
        wb(1'b0, 8'h1C, 32'h0, r);
        chk(r, 32'h0);
        chk({30'h0, rd_b, wr_b}, 32'h3);
        $display("reset test done");
    endtask
    // mux write then demux read back through the partner
    task automatic t_data;
        logic [31:0] r;
        wb(1'b1, REG_ADDR, 32'h5, r);
        wb(1'b1, REG_WDATA, 32'hA5C3, r);
        cycle(32'h22, 5'h0, r);
        cycle(32'h00, 5'h1, r);
        wb(1'b0, REG_RDATA, 32'h0, r);
        chk(r, 32'hA5C3);
        chk(32'(low_clks), 32'h10);
        $display("data test done");
    endtask
    task automatic t_sync;
        rdy_case(32'h0C, 4'h2, 5'h0, 2);
        rdy_case(32'h04, 4'h1, 5'h2, 0);
        $display("sync ready test done");
    endtask
    task automatic t_async;
        rdy_case(32'h1C, 4'h0, 5'h0, 1);
        rdy_case(32'h14, 4'h2, 5'h0, 3);
        $display("async ready test done");
    endtask
    task automatic t_nordy;
        logic [31:0] r;
        rdy_case(32'h08, 4'h3, 5'h1, 0);
        // long outer phases, clamped setup; access length stays put
        tim_x = 32'h0030_0137;
        rdy_case(32'h0C, 4'h0, 5'h0, 0);
        wb(1'b0, REG_TIMING, 32'h0, r);
        chk(r, 32'h0030_0135);
        $display("no ready test done");
    endtask
    task automatic stop_test;
        $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        t_reset;
        t_data;
        t_sync;
        t_async;
        t_nordy;
        stop_test;
    end
    // about 40 to 130 clk per bus cycle test; far more cuts a hang
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        stop_test;
    end
endmodule
